// ==== vsse_pkg.sv ====
package vsse_pkg;
  // Register numbers in the system-register space.
  localparam logic [9:0] VSSE_SR_STATUS = 10'h200;
  localparam logic [9:0] VSSE_SR_HOFFSET = 10'h210;
  localparam logic [9:0] VSSE_SR_PREFIX = 10'h03F;
  localparam logic [9:0] VSSE_SR_SAVED_PC = 10'h01A;
  localparam logic [9:0] VSSE_SR_SAVED_MS = 10'h01B;
  localparam logic [9:0] VSSE_SR_SYNDROME = 10'h03E;
  localparam logic [9:0] VSSE_SR_MSTATE = 10'h3FF;
  localparam logic [31:0] VSSE_STATUS_RESET = 32'h00000000;
  // Status bits as little-endian positions (printed bit 32+k sits at 31-k).
  localparam int VSSE_HI_STICKY = 31;
  localparam int VSSE_HI_FLAG = 30;
  localparam int VSSE_LO_STICKY = 15;
  localparam int VSSE_LO_FLAG = 14;
  localparam logic [31:0] VSSE_STATUS_RSVD = 32'h00C00080;
  // Machine state: keep critical, machine-check and debug enables.
  localparam int VSSE_MS_AVAIL = 25;
  localparam logic [31:0] VSSE_MS_KEEP = 32'h00021200;
  localparam int VSSE_SYN_VEC = 7;
  localparam logic [31:0] VSSE_SYN_VEC_ONLY = 32'h00000080;
  localparam int VSSE_OFF_LSB = 4;
  localparam int VSSE_OFF_W = 12;
  localparam int VSSE_PFX_W = 16;
  typedef enum logic [2:0] {
    VSSE_OP_NONE = 3'b000,
    VSSE_OP_BASE = 3'b001,
    VSSE_OP_VEC = 3'b010,
    VSSE_OP_CMP = 3'b011,
    VSSE_OP_MAC = 3'b100,
    VSSE_OP_ACCINIT = 3'b101,
    VSSE_OP_BITREV = 3'b110
  } vsse_op_e;
endpackage

// ==== vsse_regfile.sv ====
`timescale 1ns/100ps
module vsse_regfile (
  input wire logic ref_clk_i,               // Core clock.
  input wire logic [4:0] rd_addr_i,         // Read index.
  output logic [63:0] rd_data_o,            // Registered read data.
  input wire logic wr_hi_en_i,              // Write element 0 (upper half).
  input wire logic wr_lo_en_i,              // Write element 1 (lower half).
  input wire logic [4:0] wr_addr_i,         // Write index.
  input wire logic [63:0] wr_data_i         // Write data.
);
  import vsse_pkg::*;
  logic [63:0] mem [32];

  // Element 0 (printed bits 0:31) lives in [63:32]; element 1 in [31:0].
  always_ff @(posedge ref_clk_i) begin
    if (wr_hi_en_i) begin
      mem[wr_addr_i][63:32] <= wr_data_i[63:32];
    end
    if (wr_lo_en_i) begin
      mem[wr_addr_i][31:0] <= wr_data_i[31:0];
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ==== vsse_cmp.sv ====
`timescale 1ns/100ps
module vsse_cmp (
  input wire logic [63:0] a_i,              // First operand.
  input wire logic [63:0] b_i,              // Second operand.
  input wire logic [1:0] kind_i,            // 0 eq, 1 gt, 2 lt.
  input wire logic signed_i,                // Signed compare.
  output logic [3:0] field_o                // High, low, or, and.
);
  import vsse_pkg::*;
  logic [1:0] res;

  // One comparator per element.
  for (genvar e = 0; e < 2; e++) begin : g_el
    logic [31:0] x;
    logic [31:0] y;
    logic gt;
    logic lt;
    assign x = a_i[32*e +: 32];
    assign y = b_i[32*e +: 32];
    assign gt = signed_i ? ($signed(x) > $signed(y)) : (x > y);
    assign lt = signed_i ? ($signed(x) < $signed(y)) : (x < y);
    assign res[e] = (kind_i == 2'h1) ? gt : (kind_i == 2'h2) ? lt : (x == y);
  end

  assign field_o = {res[1], res[0], res[1] | res[0], res[1] & res[0]};
endmodule

// ==== vsse_core.sv ====
`timescale 1ns/100ps
module vsse_core (
  input wire logic ref_clk_i,                   // Core clock, 250 MHz.
  input wire logic srst_i,                      // Synchronous reset, high.
  input wire logic issue_i,                     // Instruction issued this cycle.
  input wire vsse_pkg::vsse_op_e op_i,          // Operation class.
  input wire logic [31:0] pc_i,                 // Instruction effective address.
  input wire logic [4:0] dest_i,                // Destination register.
  input wire logic [4:0] rd_idx_i,              // Register read index.
  output logic [63:0] rd_data_o,                // Register read data.
  input wire logic [63:0] result_i,             // Result from the datapath.
  input wire logic [1:0] lane_mode_i,           // 0 scalar64, 1 two 32, 2 four 16.
  input wire logic ovf_hi_i,                    // Upper-half overflow.
  input wire logic ovf_lo_i,                    // Low-element overflow.
  input wire logic [63:0] cmp_a_i,              // Compare operand a.
  input wire logic [63:0] cmp_b_i,              // Compare operand b.
  input wire logic [1:0] cmp_kind_i,            // Compare kind.
  input wire logic cmp_signed_i,                // Compare signedness.
  input wire logic [2:0] cmp_field_i,           // Condition field select.
  output logic [31:0] cond_flags_o,             // Condition flags register.
  input wire logic fp_upd_i,                    // Floating-point unit updates its bits.
  input wire logic [31:0] fp_bits_i,            // New floating-point bits.
  input wire logic sr_wr_i,                     // System-register write.
  input wire logic [9:0] sr_num_i,              // System-register number.
  input wire logic [31:0] sr_wdata_i,           // System-register write data.
  input wire logic privileged_i,                // Current access is privileged.
  output logic [31:0] sr_rdata_o,               // System-register read data.
  output logic [63:0] acc_o,                    // Accumulator.
  output logic [31:0] vector_status_control_reg_o, // Shared status/control.
  output logic [31:0] machine_state_reg_o,      // Machine state.
  output logic [31:0] saved_return_pc_o,        // Saved return address.
  output logic [31:0] saved_machine_state_o,    // Saved machine state.
  output logic [31:0] exception_syndrome_reg_o, // Syndrome.
  output logic trap_o,                          // Unavailable trap taken (pulse).
  output logic [31:0] handler_addr_o            // Handler fetch address.
);
  import vsse_pkg::*;

  // ****************************************
  // Operation decode
  // ****************************************
  logic op_is_vec;
  logic op_wr_lo;
  logic op_wr_hi;
  logic op_ovf;
  logic op_mac;
  logic op_cmp;
  logic op_accinit;
  always_comb begin
    op_is_vec = 1'b0;
    op_wr_lo = 1'b0;
    op_wr_hi = 1'b0;
    op_ovf = 1'b0;
    op_mac = 1'b0;
    op_cmp = 1'b0;
    op_accinit = 1'b0;
    unique case (op_i)
      VSSE_OP_NONE: ;
      VSSE_OP_BASE: begin
        op_wr_lo = 1'b1;
      end
      VSSE_OP_VEC: begin
        op_is_vec = 1'b1;
        op_wr_lo = 1'b1;
        op_wr_hi = 1'b1;
        op_ovf = 1'b1;
      end
      VSSE_OP_CMP: begin
        op_is_vec = 1'b1;
        op_cmp = 1'b1;
      end
      VSSE_OP_MAC: begin
        op_is_vec = 1'b1;
        op_wr_lo = 1'b1;
        op_wr_hi = 1'b1;
        op_ovf = 1'b1;
        op_mac = 1'b1;
      end
      VSSE_OP_ACCINIT: begin
        op_is_vec = 1'b1;
        op_accinit = 1'b1;
      end
      // Bit-reversed increment never touches the upper half, so it runs while the unit is off.
      VSSE_OP_BITREV: begin
        op_wr_lo = 1'b1;
      end
      // The last code is never issued; it decodes to a bubble.
      default: ;
    endcase
  end

  // ****************************************
  // Availability gate
  // ****************************************
  logic is_vec;
  logic trap;
  logic exec;
  assign is_vec = op_is_vec;
  assign trap = issue_i && is_vec && !machine_state_reg_o[VSSE_MS_AVAIL];
  // A trapped instruction is fully suppressed, so every register-file, accumulator, flag and overflow write below uses exec.
  assign exec = issue_i && !trap;

  // ****************************************
  // General registers
  // ****************************************
  logic wr_hi;
  logic wr_lo;
  logic [63:0] wr_data;
  logic [63:0] lane_val;
  logic [63:0] mac_val;
  assign wr_lo = exec && op_wr_lo;
  // Base and bit-reversed ops leave the upper half alone.
  assign wr_hi = exec && op_wr_hi;
  assign wr_data = mac_val;

  vsse_regfile u_rf (
    .ref_clk_i(ref_clk_i),
    .rd_addr_i(rd_idx_i),
    .rd_data_o(rd_data_o),
    .wr_hi_en_i(wr_hi),
    .wr_lo_en_i(wr_lo),
    .wr_addr_i(dest_i),
    .wr_data_i(wr_data)
  );

  // ****************************************
  // Lane packing and accumulator
  // ****************************************
  always_comb begin
    unique case (lane_mode_i)
      2'h1: lane_val = {result_i[63:32], result_i[31:0]};
      2'h2: lane_val = {result_i[63:48], result_i[47:32], result_i[31:16], result_i[15:0]};
      default: lane_val = result_i;
    endcase
  end
  // Scalar accumulates add 64 bits; element accumulates add each 32-bit half apart.
  always_comb begin
    if (op_i != VSSE_OP_MAC) begin
      mac_val = lane_val;
    end else if (lane_mode_i == 2'h0) begin
      mac_val = acc_o + lane_val;
    end else begin
      mac_val = {acc_o[63:32] + lane_val[63:32], acc_o[31:0] + lane_val[31:0]};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      acc_o <= 64'h0000000000000000;
    end else if (exec && op_mac) begin
      acc_o <= mac_val;
    end else if (exec && op_accinit) begin
      acc_o <= result_i;
    end
  end

  // ****************************************
  // Condition flags
  // ****************************************
  logic [3:0] cmp_field;
  vsse_cmp u_cmp (
    .a_i(cmp_a_i),
    .b_i(cmp_b_i),
    .kind_i(cmp_kind_i),
    .signed_i(cmp_signed_i),
    .field_o(cmp_field)
  );
  // Field 0 is the most significant nibble; no other op touches these flags.
  logic [4:0] cmp_lsb;
  // Inverting the field number counts down from the top nibble without a subtractor.
  assign cmp_lsb = {~cmp_field_i, 2'b00};
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cond_flags_o <= 32'h00000000;
    end else if (exec && op_cmp) begin
      cond_flags_o[cmp_lsb +: 4] <= cmp_field;
    end
  end

  // ****************************************
  // Shared status/control register
  // ****************************************
  logic sr_wr_status;
  logic [31:0] next_status;
  logic [31:0] int_field_mask;
  assign sr_wr_status = sr_wr_i && (sr_num_i == VSSE_SR_STATUS);
  always_comb begin
    int_field_mask = 32'h00000000;
    int_field_mask[VSSE_HI_STICKY] = 1'b1;
    int_field_mask[VSSE_HI_FLAG] = 1'b1;
    int_field_mask[VSSE_LO_STICKY] = 1'b1;
    int_field_mask[VSSE_LO_FLAG] = 1'b1;
  end
  always_comb begin
    next_status = vector_status_control_reg_o;
    if (sr_wr_status) begin
      next_status = sr_wdata_i;
    end
    if (fp_upd_i) begin
      // Both units share one copy; the FP side owns its fields only.
      next_status = (next_status & int_field_mask) | (fp_bits_i & ~int_field_mask);
    end
    if (exec && op_ovf) begin
      // Flags follow each instruction; stickies only accumulate, set beats the write.
      next_status[VSSE_HI_FLAG] = ovf_hi_i;
      next_status[VSSE_LO_FLAG] = ovf_lo_i;
      if (ovf_hi_i) begin
        next_status[VSSE_HI_STICKY] = 1'b1;
      end
      if (ovf_lo_i) begin
        next_status[VSSE_LO_STICKY] = 1'b1;
      end
    end
    next_status = next_status & ~VSSE_STATUS_RSVD;
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      vector_status_control_reg_o <= VSSE_STATUS_RESET;
    end else begin
      vector_status_control_reg_o <= next_status;
    end
  end

  // ****************************************
  // Handler registers
  // ****************************************
  logic sr_wr_priv;
  logic [VSSE_OFF_W-1:0] handler_offset;
  logic [VSSE_PFX_W-1:0] handler_prefix;
  // Unprivileged writes to these numbers are dropped silently rather than trapped here.
  assign sr_wr_priv = sr_wr_i && privileged_i;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      handler_offset <= '0;
    end else if (sr_wr_priv && (sr_num_i == VSSE_SR_HOFFSET)) begin
      handler_offset <= sr_wdata_i[VSSE_OFF_LSB +: VSSE_OFF_W];
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      handler_prefix <= '0;
    end else if (sr_wr_priv && (sr_num_i == VSSE_SR_PREFIX)) begin
      handler_prefix <= sr_wdata_i[31 -: VSSE_PFX_W];
    end
  end

  // ****************************************
  // Saved state
  // ****************************************
  // A trap outranks a software write in the same cycle, so the saved copy is never torn.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      saved_return_pc_o <= 32'h00000000;
    end else if (trap) begin
      saved_return_pc_o <= pc_i;
    end else if (sr_wr_priv && (sr_num_i == VSSE_SR_SAVED_PC)) begin
      saved_return_pc_o <= sr_wdata_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      saved_machine_state_o <= 32'h00000000;
    end else if (trap) begin
      saved_machine_state_o <= machine_state_reg_o;
    end else if (sr_wr_priv && (sr_num_i == VSSE_SR_SAVED_MS)) begin
      saved_machine_state_o <= sr_wdata_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      machine_state_reg_o <= 32'h00000000;
    end else if (trap) begin
      machine_state_reg_o <= machine_state_reg_o & VSSE_MS_KEEP;
    end else if (sr_wr_priv && (sr_num_i == VSSE_SR_MSTATE)) begin
      machine_state_reg_o <= sr_wdata_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      exception_syndrome_reg_o <= 32'h00000000;
    end else if (trap) begin
      exception_syndrome_reg_o <= VSSE_SYN_VEC_ONLY;
    end else if (sr_wr_priv && (sr_num_i == VSSE_SR_SYNDROME)) begin
      exception_syndrome_reg_o <= sr_wdata_i;
    end
  end

  // ****************************************
  // Trap pulse and handler address
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      trap_o <= 1'b0;
    end else begin
      trap_o <= trap;
    end
  end
  // The address is rebuilt every cycle, so it trails a handler register write by one clock.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      handler_addr_o <= 32'h00000000;
    end else begin
      handler_addr_o <= {handler_prefix, handler_offset, 4'h0};
    end
  end

  // ****************************************
  // Register read-back
  // ****************************************
  always_comb begin
    unique case (sr_num_i)
      VSSE_SR_STATUS: sr_rdata_o = vector_status_control_reg_o;
      VSSE_SR_HOFFSET: sr_rdata_o = privileged_i ? {16'h0000, handler_offset, 4'h0} : 32'h00000000;
      VSSE_SR_PREFIX: sr_rdata_o = privileged_i ? {handler_prefix, 16'h0000} : 32'h00000000;
      VSSE_SR_MSTATE: sr_rdata_o = machine_state_reg_o;
      VSSE_SR_SAVED_PC: sr_rdata_o = saved_return_pc_o;
      VSSE_SR_SAVED_MS: sr_rdata_o = saved_machine_state_o;
      VSSE_SR_SYNDROME: sr_rdata_o = exception_syndrome_reg_o;
      default: sr_rdata_o = 32'h00000000;
    endcase
  end
endmodule

// ==== vsse_core_sva.sv ====
`timescale 1ns/100ps
module vsse_core_chk import vsse_pkg::*; (
  input wire logic ref_clk_i, // Clock.
  input wire logic srst_i, // Reset.
  input wire logic issue_i, // Issue.
  input wire vsse_pkg::vsse_op_e op_i, // Class.
  input wire logic [31:0] pc_i, // Address.
  input wire logic ovf_hi_i, // High overflow.
  input wire logic sr_wr_i, // Write strobe.
  input wire logic [9:0] sr_num_i, // Number.
  input wire logic [63:0] acc_o, // Accumulator.
  input wire logic [31:0] cond_flags_o, // Flags.
  input wire logic [31:0] vector_status_control_reg_o, // Status.
  input wire logic [31:0] machine_state_reg_o, // State.
  input wire logic [31:0] saved_return_pc_o, // Saved address.
  input wire logic [31:0] saved_machine_state_o, // Saved state.
  input wire logic [31:0] exception_syndrome_reg_o, // Syndrome.
  input wire logic trap_o // Trap pulse.
);
  // ****
  // Trap condition
  // ****
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic take;
  logic [31:0] st;
  assign st = vector_status_control_reg_o;
  assign take = issue_i && !machine_state_reg_o[VSSE_MS_AVAIL] &&
    (op_i inside {VSSE_OP_VEC, VSSE_OP_CMP, VSSE_OP_MAC, VSSE_OP_ACCINIT});
  trap_raise_a: assert property (take |=> trap_o) else $error("trap missing");
  bitrev_free_a: assert property (issue_i && op_i == VSSE_OP_BITREV |=> !trap_o) else $error("bitrev trapped");
  trap_quiet_a: assert property (take |=> $stable(acc_o) && $stable(cond_flags_o)) else $error("trap updated");
  save_state_a: assert property (take |=> saved_return_pc_o == $past(pc_i) &&
    saved_machine_state_o == $past(machine_state_reg_o)) else $error("save wrong");
  state_clear_a: assert property (take |=> machine_state_reg_o == ($past(machine_state_reg_o) & VSSE_MS_KEEP))
    else $error("state wrong");
  syndrome_set_a: assert property (take |=> exception_syndrome_reg_o == VSSE_SYN_VEC_ONLY) else $error("syndrome wrong");
  hi_wrap_a: assert property (issue_i && op_i == VSSE_OP_VEC && machine_state_reg_o[VSSE_MS_AVAIL] && ovf_hi_i
    |=> st[VSSE_HI_STICKY] && st[VSSE_HI_FLAG]) else $error("high wrap lost");
  sticky_hold_a: assert property (st[VSSE_HI_STICKY] && !(sr_wr_i && sr_num_i == VSSE_SR_STATUS)
    |=> st[VSSE_HI_STICKY]) else $error("sticky dropped");
  rsvd_zero_a: assert property ((st & VSSE_STATUS_RSVD) == 32'h0) else $error("reserved set");
  reset_clear_a: assert property ($fell(srst_i) |-> st == VSSE_STATUS_RESET && !trap_o) else $error("reset wrong");
  cover property (take);
  cover property (issue_i && op_i == VSSE_OP_MAC);
  cover property (issue_i && op_i == VSSE_OP_CMP);
endmodule
bind vsse_core vsse_core_chk vsse_core_chk_inst (.ref_clk_i, .srst_i, .issue_i, .op_i, .pc_i, .ovf_hi_i, .sr_wr_i,
  .sr_num_i, .acc_o, .cond_flags_o, .vector_status_control_reg_o, .machine_state_reg_o, .saved_return_pc_o,
  .saved_machine_state_o, .exception_syndrome_reg_o, .trap_o);

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import vsse_pkg::*;
  logic ref_clk_i = 1'h0, srst_i = 1'h1, issue_i = 1'h0, cmp_signed_i = 1'h0, fp_upd_i = 1'h0;
  logic sr_wr_i = 1'h0, privileged_i = 1'h0, ovf_hi_i = 1'h0, ovf_lo_i = 1'h0, trap_o;
  vsse_op_e op_i = VSSE_OP_NONE;
  vsse_op_e ops [4] = '{VSSE_OP_VEC, VSSE_OP_CMP, VSSE_OP_MAC, VSSE_OP_ACCINIT};
  logic [31:0] pc_i = 32'h0, fp_bits_i = 32'h0, sr_wdata_i = 32'h0, cond_flags_o, sr_rdata_o, ms_exp;
  logic [31:0] vector_status_control_reg_o, machine_state_reg_o, saved_return_pc_o;
  logic [31:0] saved_machine_state_o, exception_syndrome_reg_o, handler_addr_o;
  logic [4:0] dest_i = 5'h0, rd_idx_i = 5'h0;
  logic [63:0] result_i = 64'h0, cmp_a_i = 64'h0, cmp_b_i = 64'h0, rd_data_o, acc_o;
  logic [1:0] lane_mode_i = 2'h0, cmp_kind_i = 2'h0;
  logic [2:0] cmp_field_i = 3'h0;
  logic [9:0] sr_num_i = 10'h0;
  int fail_count = 0, checks = 0, cycles = 0;
  vsse_core vsse_core_inst (.ref_clk_i, .srst_i, .issue_i, .op_i, .pc_i, .dest_i, .rd_idx_i, .rd_data_o, .result_i,
    .lane_mode_i, .ovf_hi_i, .ovf_lo_i, .cmp_a_i, .cmp_b_i, .cmp_kind_i, .cmp_signed_i, .cmp_field_i,
    .cond_flags_o, .fp_upd_i, .fp_bits_i, .sr_wr_i, .sr_num_i, .sr_wdata_i, .privileged_i, .sr_rdata_o, .acc_o,
    .vector_status_control_reg_o, .machine_state_reg_o, .saved_return_pc_o, .saved_machine_state_o,
    .exception_syndrome_reg_o, .trap_o, .handler_addr_o);
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // The ceiling sits well above the roughly 60 cycles the sequence needs.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****
  // Access tasks
  // ****
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic sr_write(input logic [9:0] num, input logic [31:0] data, input logic priv);
    sr_wr_i = 1'h1;
    sr_num_i = num;
    sr_wdata_i = data;
    privileged_i = priv;
    tick();
    sr_wr_i = 1'h0;
    tick();
  endtask
  // Issue stays high on return so outputs that stand one cycle can be seen; idle lowers it.
  task automatic exec(input vsse_op_e op, input logic [4:0] dest, input logic [63:0] res, input logic hi);
    op_i = op;
    dest_i = dest;
    result_i = res;
    ovf_hi_i = hi;
    issue_i = 1'h1;
    tick();
  endtask
  task automatic idle();
    issue_i = 1'h0;
    tick();
  endtask
  task automatic gpr_read(input logic [4:0] idx, input logic [63:0] exp);
    rd_idx_i = idx;
    tick();
    check("gpr", rd_data_o, exp);
  endtask
  task automatic do_cmp(input logic [63:0] a, input logic [63:0] b, input logic [1:0] k, input logic s,
    input logic [2:0] f);
    cmp_a_i = a;
    cmp_b_i = b;
    cmp_kind_i = k;
    cmp_signed_i = s;
    cmp_field_i = f;
    exec(VSSE_OP_CMP, 5'h00, 64'h0, 1'h0);
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (3) tick();
    srst_i = 1'h0;
    sr_num_i = VSSE_SR_STATUS;
    tick();
    check("status rd", sr_rdata_o, 32'h0);
    sr_write(VSSE_SR_MSTATE, 32'h0202_1201, 1'h1);
    exec(VSSE_OP_VEC, 5'h03, 64'h1111_2222_3333_4444, 1'h0);
    exec(VSSE_OP_BASE, 5'h03, 64'hAAAA_BBBB_CCCC_DDDD, 1'h0);
    idle();
    gpr_read(5'h03, 64'h1111_2222_CCCC_DDDD);
    exec(VSSE_OP_VEC, 5'h04, 64'h0, 1'h1);
    check("hi wrap", vector_status_control_reg_o, 32'hC000_0000);
    ovf_lo_i = 1'h1;
    exec(VSSE_OP_VEC, 5'h04, 64'h0, 1'h0);
    check("lo wrap", vector_status_control_reg_o, 32'h8000_C000);
    ovf_lo_i = 1'h0;
    exec(VSSE_OP_VEC, 5'h04, 64'h0, 1'h0);
    idle();
    check("sticky", vector_status_control_reg_o, 32'h8000_8000);
    sr_write(VSSE_SR_STATUS, 32'hFFFF_FFFF, 1'h0);
    check("rsvd", vector_status_control_reg_o, 32'hFF3F_FF7F);
    sr_write(VSSE_SR_STATUS, 32'h0, 1'h0);
    fp_upd_i = 1'h1;
    fp_bits_i = 32'hFFFF_FFFF;
    tick();
    fp_upd_i = 1'h0;
    tick();
    check("fp share", vector_status_control_reg_o, 32'h3F3F_3F7F);
    sr_write(VSSE_SR_STATUS, 32'h0, 1'h0);
    do_cmp(64'h0000_0005_0000_0009, 64'h0000_0005_0000_0003, 2'h0, 1'h0, 3'h0);
    do_cmp(64'h0000_0005_0000_0009, 64'h0000_0005_0000_0003, 2'h1, 1'h0, 3'h1);
    do_cmp(64'hFFFF_FFFF_0000_0001, 64'h0000_0005_0000_0003, 2'h2, 1'h0, 3'h6);
    do_cmp(64'hFFFF_FFFF_0000_0001, 64'h0000_0005_0000_0003, 2'h2, 1'h1, 3'h7);
    idle();
    check("cond", cond_flags_o, 32'hA600_006F);
    exec(VSSE_OP_ACCINIT, 5'h05, 64'h0000_0001_0000_0002, 1'h0);
    check("acc init", acc_o, 64'h0000_0001_0000_0002);
    exec(VSSE_OP_MAC, 5'h05, 64'h0000_0000_FFFF_FFFF, 1'h0);
    check("mac 64", acc_o, 64'h0000_0002_0000_0001);
    lane_mode_i = 2'h1;
    exec(VSSE_OP_MAC, 5'h06, 64'h0000_0000_FFFF_FFFF, 1'h0);
    idle();
    check("mac 2x32", acc_o, 64'h0000_0002_0000_0000);
    gpr_read(5'h06, 64'h0000_0002_0000_0000);
    lane_mode_i = 2'h2;
    exec(VSSE_OP_VEC, 5'h08, 64'h8001_7FFF_0001_FFFF, 1'h0);
    idle();
    gpr_read(5'h08, 64'h8001_7FFF_0001_FFFF);
    sr_write(VSSE_SR_PREFIX, 32'hABCD_0000, 1'h1);
    sr_write(VSSE_SR_HOFFSET, 32'h0000_5555, 1'h1);
    sr_write(VSSE_SR_HOFFSET, 32'h0000_3333, 1'h0);
    check("off user", sr_rdata_o, 32'h0);
    privileged_i = 1'h1;
    tick();
    check("off priv", sr_rdata_o, 32'h0000_5550);
    check("handler", handler_addr_o, 32'hABCD_5550);
    sr_write(VSSE_SR_SYNDROME, 32'hFFFF_FFFF, 1'h1);
    sr_write(VSSE_SR_MSTATE, 32'h0002_1E05, 1'h1);
    ms_exp = 32'h0002_1E05;
    for (int i = 0; i < 4; i++) begin
      pc_i = 32'h0000_1000 + 32'(i);
      exec(ops[i], 5'h03, 64'h0, 1'h1);
      check("trap", trap_o, 1'h1);
      check("spc", saved_return_pc_o, pc_i);
      check("sms", saved_machine_state_o, ms_exp);
      check("ms", machine_state_reg_o, 32'h0002_1200);
      check("syn", exception_syndrome_reg_o, 32'h0000_0080);
      ms_exp = 32'h0002_1200;
    end
    idle();
    check("trap end", trap_o, 1'h0);
    check("acc kept", acc_o, 64'h0000_0002_0000_0000);
    check("cond kept", cond_flags_o, 32'hA600_006F);
    check("stat kept", vector_status_control_reg_o, 32'h0);
    gpr_read(5'h03, 64'h1111_2222_CCCC_DDDD);
    exec(VSSE_OP_BITREV, 5'h07, 64'h0, 1'h0);
    check("bitrev", trap_o, 1'h0);
    idle();
    sr_write(VSSE_SR_STATUS, 32'h0000_0001, 1'h0);
    srst_i = 1'h1;
    tick();
    srst_i = 1'h0;
    tick();
    check("rst status", vector_status_control_reg_o, 32'h0);
    results();
  end
endmodule
